// ==== hw/eik_pkg.sv ====
package eik_pkg;
  // =====================================================
  // sizes and reset values
  localparam int KEY_LINES = 8;
  localparam logic [7:0] KEY_DIR_RST = 8'h00;
  localparam logic [7:0] KEY_OUT_RST = 8'h00;
  localparam logic [1:0] SYNC_RST = 2'h3;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] dout;
  } eik_port_ctl_type;
endpackage

// ==== hw/eik_irq_logic.sv ====
`timescale 1ns/1ps
// Summary of operation
// [R1] The dedicated request pin triggers on falling edges only, or on falling edges plus sustained low level, chosen by a build-time parameter.
// [R2] Keyboard line requests are always falling-edge only, whatever the pin trigger option.
// [R3] All keyboard lines are ORed into the shared request, raising it on any falling edge while the function is enabled.
// [R4] Every keyboard line is an input after reset, and software may later change individual directions.
// [R5] The dedicated pin is accepted as an asynchronous request and delivered to the CPU interrupt logic.
// [R6] Pin and keyboard lines are synchronised and falling edges found by comparing successive synchronised samples before latching.
module eik_irq_logic
  import eik_pkg::*;
#(
  parameter bit LEVEL_TRIG = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic irq_n_pin,
  input wire logic [KEY_LINES-1:0] key_in,
  input wire logic irq_en,
  input wire logic irq_ack,
  input wire logic ctl_we,
  input wire eik_port_ctl_type ctl_wdata,
  output logic irq_req,
  output logic [KEY_LINES-1:0] key_out,
  output logic [KEY_LINES-1:0] key_oe,
  output logic [KEY_LINES-1:0] key_sync
);
  // =====================================================
  // synchronisers
  // pins are asynchronous; two stages before any logic looks at them
  // costs two cycles of request latency, buys metastability margin
  logic [1:0] irq_s_ff;
  logic irq_prev_ff;
  logic [KEY_LINES-1:0] key_s1_ff;
  logic [KEY_LINES-1:0] key_s2_ff;
  logic [KEY_LINES-1:0] key_prev_ff;
  logic pend_ff;
  eik_port_ctl_type ctl_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_s_ff <= SYNC_RST;
      key_s1_ff <= '1;
      key_s2_ff <= '1;
    end else if (clk_en) begin
      irq_s_ff <= {irq_s_ff[0], irq_n_pin}; // R5 R6
      key_s1_ff <= key_in;
      key_s2_ff <= key_s1_ff; // R6
    end
  end

  // previous samples; reset high, so a line held low through reset shows as an edge once synchronised
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_prev_ff <= 1'b1;
      key_prev_ff <= '1;
    end else if (clk_en) begin
      irq_prev_ff <= irq_s_ff[1];
      key_prev_ff <= key_s2_ff;
    end
  end

  // =====================================================
  // edge detect and pending latch
  // edges only compare settled samples, never the first stage
  logic pin_fall;
  logic key_fall;
  logic pin_low;
  assign pin_fall = irq_prev_ff & ~irq_s_ff[1]; // R6
  assign key_fall = |(key_prev_ff & ~key_s2_ff); // R2 R3
  assign pin_low = LEVEL_TRIG & ~irq_s_ff[1]; // R1

  // set wins over acknowledge so an edge in the ack cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (pin_fall | key_fall) begin
        pend_ff <= 1'b1; // R1 R3
      end else if (irq_ack) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // level mode keeps requesting while the pin stays low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_req <= 1'b0;
    end else if (clk_en) begin
      irq_req <= irq_en & (pend_ff | pin_low); // R1 R5
    end
  end

  // =====================================================
  // keyboard line direction and data
  // direction reaches the pins one cycle after the write lands
  // all lines come up as inputs so nothing fights an external switch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_ff <= '{dir: KEY_DIR_RST, dout: KEY_OUT_RST}; // R4
    end else if (clk_en && ctl_we) begin
      ctl_ff <= ctl_wdata; // R4
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_out <= KEY_OUT_RST;
      key_oe <= KEY_DIR_RST;
      key_sync <= '1;
    end else if (clk_en) begin
      key_out <= ctl_ff.dout;
      key_oe <= ctl_ff.dir; // R4
      key_sync <= key_s2_ff;
    end
  end

  // =====================================================
  // checks
  // clock enable low must hold every register where it was
  property p_r2_key_edge;
    @(posedge clk) disable iff (!nrst)
      (clk_en && key_fall && irq_en && !irq_ack) ##1 clk_en |=> irq_req;
  endproperty
  a_r2_key_edge: assert property (p_r2_key_edge) else $error("key edge lost"); // R2

  property p_r3_or;
    @(posedge clk) disable iff (!nrst)
      (clk_en && (pin_fall || key_fall)) |=> pend_ff;
  endproperty
  a_r3_or: assert property (p_r3_or) else $error("edge not latched"); // R3

  property p_r1_edge_only;
    @(posedge clk) disable iff (!nrst)
      (clk_en && !LEVEL_TRIG && !pend_ff) |=> !irq_req;
  endproperty
  a_r1_edge_only: assert property (p_r1_edge_only) else $error("level seen in edge mode"); // R1

  property p_r1_level;
    @(posedge clk) disable iff (!nrst)
      (clk_en && LEVEL_TRIG && irq_en && !irq_s_ff[1]) |=> irq_req;
  endproperty
  a_r1_level: assert property (p_r1_level) else $error("low level missed"); // R1

  property p_r4_dir;
    @(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> key_oe == KEY_DIR_RST;
  endproperty
  a_r4_dir: assert property (p_r4_dir) else $error("lines not input after reset"); // R4

  property p_r5_mask;
    @(posedge clk) disable iff (!nrst)
      (clk_en && !irq_en) |=> !irq_req;
  endproperty
  a_r5_mask: assert property (p_r5_mask) else $error("request while disabled"); // R5

  property p_r6_sync;
    @(posedge clk) disable iff (!nrst)
      (clk_en && (&irq_s_ff)) |=> !pin_fall;
  endproperty
  a_r6_sync: assert property (p_r6_sync) else $error("edge before sync"); // R6

  property p_ack_clear;
    @(posedge clk) disable iff (!nrst)
      (clk_en && irq_ack && !pin_fall && !key_fall) |=> !pend_ff;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear"); // R5

  property p_freeze_req;
    @(posedge clk) disable iff (!nrst)
      !clk_en |=> $stable(irq_req) && $stable(pend_ff);
  endproperty
  a_freeze_req: assert property (p_freeze_req) else $error("request moved while frozen");

  property p_freeze_ctl;
    @(posedge clk) disable iff (!nrst)
      !clk_en |=> $stable(key_oe) && $stable(key_out) && $stable(key_sync);
  endproperty
  a_freeze_ctl: assert property (p_freeze_ctl) else $error("lines moved while frozen");

  property p_r4_load;
    @(posedge clk) disable iff (!nrst)
      clk_en |=> key_oe == $past(ctl_ff.dir);
  endproperty
  a_r4_load: assert property (p_r4_load) else $error("direction not applied"); // R4

  property p_r3_hold;
    @(posedge clk) disable iff (!nrst)
      (clk_en && pend_ff && !irq_ack) |=> pend_ff;
  endproperty
  a_r3_hold: assert property (p_r3_hold) else $error("pending dropped without ack"); // R3

  property p_r5_out;
    @(posedge clk) disable iff (!nrst)
      (clk_en && irq_en && pend_ff) |=> irq_req;
  endproperty
  a_r5_out: assert property (p_r5_out) else $error("pending not delivered"); // R5

  property p_r6_prev;
    @(posedge clk) disable iff (!nrst)
      clk_en |=> irq_prev_ff == $past(irq_s_ff[1]);
  endproperty
  a_r6_prev: assert property (p_r6_prev) else $error("previous sample skipped"); // R6

  property p_r2_no_edge;
    @(posedge clk) disable iff (!nrst)
      (clk_en && !pend_ff && !pin_fall && !key_fall) |=> !pend_ff;
  endproperty
  a_r2_no_edge: assert property (p_r2_no_edge) else $error("pending without edge"); // R2

  c_key: cover property (@(posedge clk) disable iff (!nrst) key_fall ##2 irq_req);
  c_pin: cover property (@(posedge clk) disable iff (!nrst) pin_fall ##2 irq_req);
  c_ack: cover property (@(posedge clk) disable iff (!nrst) irq_req ##1 irq_ack);
  c_freeze: cover property (@(posedge clk) disable iff (!nrst) !clk_en ##1 clk_en);
endmodule

// ==== test/eik_sw_model.sv ====
`timescale 1ns/1ps
module eik_sw_model (
  input wire logic clk,
  output logic irq_n_pin,
  output logic [7:0] key_in
);
  // ==========
  // switches open: pull-ups hold lines high
  initial begin
    irq_n_pin = 1'b1;
    key_in = 8'hFF;
  end
  task automatic set_lines(input logic pin, input logic [7:0] keys);
    @(posedge clk);
    irq_n_pin <= pin;
    key_in <= keys;
  endtask
endmodule

// ==== test/eik_irq_logic_tb_top.sv ====
`timescale 1ns/1ps
module eik_irq_logic_tb_top;
  import eik_pkg::*;
  logic clk, nrst, clk_en, irq_en, irq_ack, ctl_we, irq_req, irq_n_pin;
  logic [7:0] key_in, key_out, key_oe, key_sync;
  eik_port_ctl_type ctl_wdata;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  eik_sw_model sw_u (.clk(clk), .irq_n_pin(irq_n_pin), .key_in(key_in));
  eik_irq_logic dut_u (.clk(clk), .nrst(nrst), .clk_en(clk_en), .irq_n_pin(irq_n_pin),
    .key_in(key_in), .irq_en(irq_en), .irq_ack(irq_ack), .ctl_we(ctl_we),
    .ctl_wdata(ctl_wdata), .irq_req(irq_req), .key_out(key_out), .key_oe(key_oe),
    .key_sync(key_sync));
  // ==========
  // helpers
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_req(input logic lvl, input int lim);
    n = 0;
    while (irq_req !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic ack_hold_check(input logic pin, input logic [7:0] keys);
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    wait_req(1'b0, 4);
    repeat (6) @(posedge clk);
    #1;
    check(irq_req === 1'b0, "request came back while line held low");
    check(key_sync === keys, "synchronised lines wrong");
    sw_u.set_lines(1'b1, 8'hFF);
    repeat (4) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_keys;
    for (int i = 0; i < 8; i++) begin
      sw_u.set_lines(1'b1, ~(8'h01 << i));
      wait_req(1'b1, 8);
      check(irq_req === 1'b1 && n == 4, "key fall not seen in 4 cycles");
      ack_hold_check(1'b1, ~(8'h01 << i));
    end
    $display("t_keys done");
  endtask
  task automatic t_mask;
    irq_en <= 1'b0;
    sw_u.set_lines(1'b1, 8'hF7);
    repeat (8) @(posedge clk);
    #1;
    check(irq_req === 1'b0, "masked request shown");
    @(posedge clk);
    irq_en <= 1'b1;
    wait_req(1'b1, 3);
    check(irq_req === 1'b1, "pending lost while masked");
    ack_hold_check(1'b1, 8'hF7);
    $display("t_mask done");
  endtask
  task automatic t_pin;
    sw_u.set_lines(1'b0, 8'hFF);
    wait_req(1'b1, 8);
    check(irq_req === 1'b1 && n == 4, "pin fall not seen in 4 cycles");
    ack_hold_check(1'b0, 8'hFF);
    $display("t_pin done");
  endtask
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    sw_u.set_lines(1'b1, 8'hFE);
    repeat (6) @(posedge clk);
    #1;
    check(irq_req === 1'b0 && key_sync === 8'hFF, "state moved while frozen");
    @(posedge clk);
    clk_en <= 1'b1;
    wait_req(1'b1, 8);
    check(irq_req === 1'b1 && n == 4, "edge lost across freeze");
    ack_hold_check(1'b1, 8'hFE);
    $display("t_freeze done");
  endtask
  task automatic t_dir;
    check(key_oe === 8'h00 && key_sync === 8'hFF && irq_req === 1'b0, "reset state");
    @(posedge clk);
    ctl_we <= 1'b1;
    ctl_wdata <= '{dir: 8'hA5, dout: 8'h3C};
    @(posedge clk);
    ctl_we <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(key_oe === 8'hA5 && key_out === 8'h3C, "direction write lost");
    $display("t_dir done");
  endtask
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    irq_en = 1'b1;
    irq_ack = 1'b0;
    ctl_we = 1'b0;
    ctl_wdata = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_dir();
    t_keys();
    t_mask();
    t_pin();
    t_freeze();
    report_and_stop();
  end
  // cap well above the few hundred cycles the scenarios need
  initial begin
    #50000;
    fail_count++;
    report_and_stop();
  end
endmodule
